// ### design/rsr_defines.svh
// Offsets, bit positions, reset values and sizes of the reader status registers
`ifndef RSR_DEFINES_SVH
`define RSR_DEFINES_SVH
`define RSR_OFS_STATUS1 6'h07
`define RSR_OFS_STATUS2 6'h08
`define RSR_OFS_FIFO_DATA 6'h09
`define RSR_OFS_THRESHOLD 6'h0b
`define RSR_OFS_BIT_FRAMING 6'h0d
`define RSR_B_CRC_ZERO 6
`define RSR_B_CRC_DONE 5
`define RSR_B_IRQ 4
`define RSR_B_TIMER 3
`define RSR_B_HI_ALERT 1
`define RSR_B_LO_ALERT 0
`define RSR_B_OVH_CLEAR 7
`define RSR_B_FORCE_FAST 6
`define RSR_B_CIPHER 3
`define RSR_B_LAUNCH 7
`define RSR_STATUS1_RESET 8'h21
`define RSR_STATUS2_RESET 8'h00
`define RSR_THRESHOLD_RESET 6'h08
`define RSR_FIFO_DEPTH 7'h40
`define RSR_TEMP_ALARM_DEGC 125
`endif

// ### design/rsr_pkg.sv
// Types shared by the reader status register block
package rsr_pkg;
  // Codes are the values software sees in the modem state field
  typedef enum logic [2:0] {
    RSR_IDLE = 3'h0,
    RSR_WAIT_LAUNCH = 3'h1,
    RSR_TX_WAIT = 3'h2,
    RSR_TX = 3'h3,
    RSR_RX_WAIT = 3'h4,
    RSR_WAIT_DATA = 3'h5,
    RSR_RX = 3'h6
  } rsr_modem_t;

  typedef struct packed {
    logic field_s1;
    logic field_s2;
    logic cool_s1;
    logic cool_s2;
    logic [6:0] fill;
    logic [5:0] thresh;
    logic crc_zero;
    logic crc_done;
    logic ovh_clear_bit;
    logic force_fast;
    logic cipher;
    logic ovh_err;
    logic crc_err;
    rsr_modem_t modem;
    logic [7:0] wcnt;
    logic [7:0] rdata;
  } rsr_state_t;
endpackage

// ### design/rsr_status_regs.sv
// Reader status registers, FIFO level alerts and modem state tracking
//
// Function
// - CRC zero-result flag, status bit 6, set when the CRC remainder is zero.
// - CRC zero-result flag reads 0 while calculating, 1 after correct completion.
// - CRC done flag, bit 5, set when a CRC compute command calculation finishes.
// - Status bit 4 is one when any enabled interrupt source is active.
// - Timer-active flag, bit 3, is one while the timer counts down.
// - In gated mode timer-active follows timer_enabled, not the gate level.
// - Nearly-full alert when 64 minus fill count is at most the threshold.
// - Nearly-empty alert when fill count is at most the threshold.
// - First status register reads 21h after reset.
// - Modem status register reads 00h after reset.
// - Writing bit 7 clears the overheat error if temperature is below 125 C.
// - Force-fast bit selects high-speed host filter; else filter follows protocol.
// - Cipher active flag set only by successful authenticate; software clears it.
// - While cipher active, card data is encrypted, standard card read/write only.
// - Modem state codes: 000 idle, 011 transmit, 101 wait data, 110 receive.
// - Modem state 001 while waiting for the transmit launch bit.
// - Modem state 010 in pre-transmit wait: minimum time, optional field wait.
// - Modem state 100 in pre-receive wait: minimum time, optional field wait.
// - Fill count rises on host data port write, falls on host read.
// - FIFO threshold is six bits, reset value 08h.
// - CRC mismatch error set when receive CRC check enabled and check fails.
`timescale 1ns/1ns
`default_nettype none
`include "rsr_defines.svh"
module rsr_status_regs #(
  parameter int WAIT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic crc_start,
  input wire logic crc_calc_done,
  input wire logic crc_remainder_zero,
  input wire logic crc_compute_command,
  input wire logic [7:0] primary_irq_req,
  input wire logic [7:0] primary_irq_enable_reg,
  input wire logic [7:0] secondary_irq_req,
  input wire logic [7:0] secondary_irq_enable_reg,
  input wire logic timer_counting,
  input wire logic timer_enabled,
  input wire logic [1:0] timer_gate_select,
  input wire logic fifo_flush,
  input wire logic temp_below_limit,
  input wire logic overheat_detect,
  input wire logic protocol_high_speed,
  input wire logic card_authenticate_done,
  input wire logic standard_card_rw,
  input wire logic receive_crc_check_enable,
  input wire logic rx_crc_fail,
  input wire logic rx_startup,
  input wire logic transceive_active,
  input wire logic wait_for_field_flag,
  input wire logic rf_field_present,
  input wire logic [WAIT_W-1:0] transmit_wait_time_reg,
  input wire logic [WAIT_W-1:0] receive_wait_time_reg,
  input wire logic tx_done,
  input wire logic rx_started,
  input wire logic rx_done,
  output logic [6:0] fifo_fill_count,
  output logic [5:0] fifo_threshold,
  output logic [2:0] modem_state_code,
  output logic overheat_error,
  output logic crc_mismatch_error,
  output logic card_cipher_active,
  output logic cipher_encrypt_enable,
  output logic filter_high_speed
);
  import rsr_pkg::*;

  rsr_state_t s;
  rsr_state_t next_s;
  logic irq_any;
  logic timer_active_flag;
  logic fifo_nearly_full_alert;
  logic fifo_nearly_empty_alert;
  logic [6:0] space_left;
  logic [7:0] status1;
  logic [7:0] status2;
  logic wr_s1;
  logic wr_s2;
  logic launch;
  logic fifo_wr;
  logic fifo_rd;
  logic wait_done;
  logic field_ok;

  // Live flag terms feeding the status words
  assign irq_any = |(primary_irq_req & primary_irq_enable_reg) |
                   |(secondary_irq_req & secondary_irq_enable_reg);
  // Gate level deliberately not an input: only the select matters
  assign timer_active_flag = (timer_gate_select != 2'h0) ? timer_enabled
                                                         : timer_counting;
  assign space_left = `RSR_FIFO_DEPTH - s.fill;
  assign fifo_nearly_full_alert = space_left <= {1'b0, s.thresh};
  assign fifo_nearly_empty_alert = s.fill <= {1'b0, s.thresh};

  // Assembled words; reserved bits tied low
  assign status1 = {1'b0, s.crc_zero, s.crc_done, irq_any, timer_active_flag,
                    1'b0, fifo_nearly_full_alert, fifo_nearly_empty_alert};
  assign status2 = {s.ovh_clear_bit, s.force_fast, 2'h0, s.cipher, s.modem};

  // Host access decode
  assign wr_s1 = reg_wr && (reg_addr == `RSR_OFS_STATUS1);
  assign wr_s2 = reg_wr && (reg_addr == `RSR_OFS_STATUS2);
  assign launch = reg_wr && (reg_addr == `RSR_OFS_BIT_FRAMING) &&
                  reg_wdata[`RSR_B_LAUNCH];
  assign fifo_wr = reg_wr && (reg_addr == `RSR_OFS_FIFO_DATA);
  assign fifo_rd = reg_rd && (reg_addr == `RSR_OFS_FIFO_DATA);
  assign wait_done = (s.wcnt == 8'h00);
  assign field_ok = !wait_for_field_flag || s.field_s2;

  // Next state of everything
  always_comb begin
    next_s = s;
    next_s.field_s1 = rf_field_present;
    next_s.field_s2 = s.field_s1;
    next_s.cool_s1 = temp_below_limit;
    next_s.cool_s2 = s.cool_s1;
    // CRC flags: a new calculation drops both; finishing loads the zero result, and sets done only for a compute command
    if (crc_start) begin
      next_s.crc_zero = 1'b0;
      next_s.crc_done = 1'b0;
    end
    if (crc_calc_done) begin
      next_s.crc_zero = crc_remainder_zero;
      if (crc_compute_command) begin
        next_s.crc_done = 1'b1;
      end
    end
    // Fill count saturates so a stray access cannot wrap it
    if (fifo_flush) begin
      next_s.fill = 7'h00;
    end else if (fifo_wr && !fifo_rd && s.fill < `RSR_FIFO_DEPTH) begin
      next_s.fill = s.fill + 7'h01;
    end else if (fifo_rd && !fifo_wr && s.fill != 7'h00) begin
      next_s.fill = s.fill - 7'h01;
    end
    if (reg_wr && reg_addr == `RSR_OFS_THRESHOLD) begin
      next_s.thresh = reg_wdata[5:0];
    end
    // Status2 writable bits; first status word takes no writes
    if (wr_s2) begin
      next_s.ovh_clear_bit = reg_wdata[`RSR_B_OVH_CLEAR];
      next_s.force_fast = reg_wdata[`RSR_B_FORCE_FAST];
      if (!reg_wdata[`RSR_B_CIPHER]) begin
        next_s.cipher = 1'b0;
      end
      if (reg_wdata[`RSR_B_OVH_CLEAR] && s.cool_s2) begin
        next_s.ovh_err = 1'b0;
      end
    end
    // Set wins over a same-cycle clear for hardware events
    if (card_authenticate_done) begin
      next_s.cipher = 1'b1;
    end
    if (overheat_detect) begin
      next_s.ovh_err = 1'b1;
    end
    if (rx_startup) begin
      next_s.crc_err = 1'b0;
    end
    if (receive_crc_check_enable && rx_crc_fail) begin
      next_s.crc_err = 1'b1;
    end
    // Modem sequence
    if (!wait_done) begin
      next_s.wcnt = s.wcnt - 8'h01;
    end
    case (s.modem)
      RSR_IDLE: begin
        if (transceive_active) begin
          next_s.modem = RSR_WAIT_LAUNCH;
        end
      end
      RSR_WAIT_LAUNCH: begin
        if (launch) begin
          next_s.modem = RSR_TX_WAIT;
          next_s.wcnt = 8'(transmit_wait_time_reg);
        end
      end
      RSR_TX_WAIT: begin
        if (wait_done && field_ok) begin
          next_s.modem = RSR_TX;
        end
      end
      RSR_TX: begin
        if (tx_done) begin
          next_s.modem = RSR_RX_WAIT;
          next_s.wcnt = 8'(receive_wait_time_reg);
        end
      end
      RSR_RX_WAIT: begin
        if (wait_done && field_ok) begin
          next_s.modem = RSR_WAIT_DATA;
        end
      end
      RSR_WAIT_DATA: begin
        if (rx_started) begin
          next_s.modem = RSR_RX;
        end
      end
      RSR_RX: begin
        if (rx_done) begin
          next_s.modem = RSR_WAIT_LAUNCH;
        end
      end
      default: begin
        next_s.modem = RSR_IDLE;
      end
    endcase
    if (!transceive_active) begin
      next_s.modem = RSR_IDLE;
    end
    // One registered snapshot per read keeps the word coherent
    if (reg_rd) begin
      case (reg_addr)
        `RSR_OFS_STATUS1: next_s.rdata = status1;
        `RSR_OFS_STATUS2: next_s.rdata = status2;
        `RSR_OFS_THRESHOLD: next_s.rdata = {2'h0, s.thresh};
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  // State register; reset values give 21h and 00h on the status words
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '{field_s1: 1'b0, field_s2: 1'b0, cool_s1: 1'b0, cool_s2: 1'b0,
             fill: 7'h00, thresh: `RSR_THRESHOLD_RESET, crc_zero: 1'b0,
             crc_done: 1'b1, ovh_clear_bit: 1'b0, force_fast: 1'b0,
             cipher: 1'b0, ovh_err: 1'b0, crc_err: 1'b0, modem: RSR_IDLE,
             wcnt: 8'h00, rdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign reg_rdata = s.rdata;
  assign fifo_fill_count = s.fill;
  assign fifo_threshold = s.thresh;
  assign modem_state_code = s.modem;
  assign overheat_error = s.ovh_err;
  assign crc_mismatch_error = s.crc_err;
  assign card_cipher_active = s.cipher;
  assign cipher_encrypt_enable = s.cipher && standard_card_rw;
  assign filter_high_speed = s.force_fast || protocol_high_speed;

  property p_crc_zero_clear;
    @(posedge core_clk) disable iff (!rst_b)
    crc_start && !crc_calc_done |=> !s.crc_zero;
  endproperty
  a_crc_zero_clear: assert property (p_crc_zero_clear)
    else $error("zero-result flag not cleared at CRC start");

  property p_crc_zero_set;
    @(posedge core_clk) disable iff (!rst_b)
    crc_calc_done && crc_remainder_zero |=> s.crc_zero;
  endproperty
  a_crc_zero_set: assert property (p_crc_zero_set)
    else $error("zero-result flag not set on zero remainder");

  property p_crc_done;
    @(posedge core_clk) disable iff (!rst_b)
    crc_calc_done && crc_compute_command |=> s.crc_done;
  endproperty
  a_crc_done: assert property (p_crc_done)
    else $error("CRC done flag missing");

  property p_irq_read;
    @(posedge core_clk) disable iff (!rst_b)
    reg_rd && reg_addr == `RSR_OFS_STATUS1 && !wr_s1 |=>
      reg_rdata[`RSR_B_IRQ] == $past(irq_any);
  endproperty
  a_irq_read: assert property (p_irq_read)
    else $error("interrupt pending bit mismatch");

  property p_alerts_read;
    @(posedge core_clk) disable iff (!rst_b)
    reg_rd && reg_addr == `RSR_OFS_STATUS1 && !wr_s1 |=>
      reg_rdata[`RSR_B_HI_ALERT] == ($past(7'h40 - s.fill) <= $past({1'b0, s.thresh})) &&
      reg_rdata[`RSR_B_LO_ALERT] == ($past(s.fill) <= $past({1'b0, s.thresh}));
  endproperty
  a_alerts_read: assert property (p_alerts_read)
    else $error("FIFO alert bits wrong");

  property p_fill_inc;
    @(posedge core_clk) disable iff (!rst_b)
    fifo_wr && !fifo_rd && !fifo_flush && s.fill < 7'h40 |=>
      s.fill == $past(s.fill) + 7'h01;
  endproperty
  a_fill_inc: assert property (p_fill_inc)
    else $error("fill count did not rise");

  property p_cipher_set;
    @(posedge core_clk) disable iff (!rst_b)
    card_authenticate_done |=> card_cipher_active;
  endproperty
  a_cipher_set: assert property (p_cipher_set)
    else $error("cipher flag not set by authenticate");

  property p_launch;
    @(posedge core_clk) disable iff (!rst_b)
    s.modem == RSR_WAIT_LAUNCH && launch && transceive_active |=>
      modem_state_code == 3'h2;
  endproperty
  a_launch: assert property (p_launch)
    else $error("launch did not enter pre-transmit wait");

  property p_overheat_clear;
    @(posedge core_clk) disable iff (!rst_b)
    wr_s2 && reg_wdata[`RSR_B_OVH_CLEAR] && s.cool_s2 && !overheat_detect |=>
      !overheat_error;
  endproperty
  a_overheat_clear: assert property (p_overheat_clear)
    else $error("overheat error not cleared");

  property p_force_fast;
    @(posedge core_clk) disable iff (!rst_b)
    wr_s2 && reg_wdata[`RSR_B_FORCE_FAST] |=> filter_high_speed;
  endproperty
  a_force_fast: assert property (p_force_fast)
    else $error("filter not forced fast");
endmodule
`default_nettype wire

// ### test/rsr_host_model.sv
// Host model that reaches the status registers by strobed register accesses
`timescale 1ns/1ns
`default_nettype none
module rsr_host_model (
  input wire logic core_clk,
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // Bus idle from time zero; every change lands on a falling edge
  initial begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One write, taken at the rising edge; released lines show junk, not the old value
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // One read; data is taken a full cycle later since it holds until the next read
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### test/reader_status_registers_test.sv
// Self-checking bench for the reader status registers
`timescale 1ns/1ns
`default_nettype none
module reader_status_registers_test;
  import rsr_pkg::*;
  logic core_clk, rst_b, crc_start, crc_calc_done, crc_remainder_zero, crc_compute_command;
  logic [7:0] primary_irq_req, primary_irq_enable_reg, secondary_irq_req;
  logic [7:0] secondary_irq_enable_reg, transmit_wait_time_reg, receive_wait_time_reg;
  logic timer_counting, timer_enabled, fifo_flush, temp_below_limit, overheat_detect;
  logic protocol_high_speed, card_authenticate_done, standard_card_rw;
  logic receive_crc_check_enable, rx_crc_fail, rx_startup, transceive_active;
  logic wait_for_field_flag, rf_field_present, tx_done, rx_started, rx_done;
  logic [1:0] timer_gate_select;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [5:0] reg_addr, fifo_threshold;
  logic reg_wr, reg_rd, overheat_error, crc_mismatch_error, card_cipher_active;
  logic cipher_encrypt_enable, filter_high_speed;
  logic [6:0] fifo_fill_count, f;
  logic [2:0] modem_state_code;
  logic [15:0] b;
  int n_fail, comparisons, n;

  rsr_host_model host (.core_clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  rsr_status_regs #(.WAIT_W(8)) dut (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .crc_start, .crc_calc_done, .crc_remainder_zero,
    .crc_compute_command, .primary_irq_req, .primary_irq_enable_reg, .secondary_irq_req,
    .secondary_irq_enable_reg, .timer_counting, .timer_enabled, .timer_gate_select,
    .fifo_flush, .temp_below_limit, .overheat_detect, .protocol_high_speed,
    .card_authenticate_done, .standard_card_rw, .receive_crc_check_enable, .rx_crc_fail,
    .rx_startup, .transceive_active, .wait_for_field_flag, .rf_field_present,
    .transmit_wait_time_reg, .receive_wait_time_reg, .tx_done, .rx_started, .rx_done,
    .fifo_fill_count, .fifo_threshold, .modem_state_code, .overheat_error,
    .crc_mismatch_error, .card_cipher_active, .cipher_encrypt_enable, .filter_high_speed);

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Counts and reports one comparison
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rchk(input string nm, input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Bounded wait for a modem code; n returns the cycles spent waiting
  task automatic wait_modem(input logic [2:0] c);
    n = 0;
    while (modem_state_code !== c && n < 50) begin
      @(negedge core_clk);
      n++;
    end
    if (modem_state_code !== c) begin
      n_fail++;
      $display("wrong value modem expected %h seen %h", c, modem_state_code);
      print_verdict();
    end
  endtask
  // Expected first status byte with threshold 4, CRC done flag set and all other sources quiet
  function automatic logic [7:0] s1(input logic [6:0] fl);
    return {6'b001000, (7'd64 - fl) <= 7'd4, fl <= 7'd4};
  endfunction

  // Main sequence; inputs move only on falling edges
  initial begin
    rst_b = 1'b0;
    {crc_start, crc_calc_done, crc_remainder_zero, crc_compute_command, primary_irq_req,
     primary_irq_enable_reg, secondary_irq_req, secondary_irq_enable_reg, timer_counting,
     timer_enabled, timer_gate_select, fifo_flush, temp_below_limit, overheat_detect,
     protocol_high_speed, card_authenticate_done, standard_card_rw, receive_crc_check_enable,
     rx_crc_fail, rx_startup, transceive_active, wait_for_field_flag, rf_field_present,
     transmit_wait_time_reg, receive_wait_time_reg, tx_done, rx_started, rx_done} = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    rchk("crc_fifo reset", 6'h07, 8'h21);
    rchk("modem_ctl reset", 6'h08, 8'h00);
    rchk("threshold reset", 6'h0b, 8'h08);
    rchk("unmapped", 6'h3f, 8'h00);
    host.wr(6'h07, 8'hff);
    rchk("crc_fifo after write", 6'h07, 8'h21);
    host.wr(6'h0b, 8'hff);
    rchk("threshold width", 6'h0b, 8'h3f);
    host.wr(6'h0b, 8'h04);
    chk("threshold port", 8'h04, {2'h0, fifo_threshold});
    // Fill past the top; both alerts flip at their boundaries
    for (int i = 1; i <= 65; i++) begin
      host.wr(6'h09, 8'(i));
      f = (i > 64) ? 7'd64 : 7'(i);
      chk("fill", {1'b0, f}, {1'b0, fifo_fill_count});
      rchk("alerts", 6'h07, s1(f));
    end
    host.rd(6'h09, v);
    chk("fill after read", 8'h3f, {1'b0, fifo_fill_count});
    @(negedge core_clk) fifo_flush = 1'b1;
    @(negedge core_clk) fifo_flush = 1'b0;
    rchk("alerts flushed", 6'h07, 8'h21);
    // CRC run under another command, then with zero and with non-zero remainder
    for (int k = 2; k >= 0; k--) begin
      crc_compute_command = (k < 2);
      @(negedge core_clk) crc_start = 1'b1;
      @(negedge core_clk) crc_start = 1'b0;
      rchk("crc busy", 6'h07, 8'h01);
      @(negedge core_clk) {crc_calc_done, crc_remainder_zero} = {1'b1, 1'(k)};
      @(negedge core_clk) crc_calc_done = 1'b0;
      rchk("crc done", 6'h07, (k == 2) ? 8'h01 : (k ? 8'h61 : 8'h21));
    end
    // Each request source alone, masked then enabled
    for (int i = 0; i < 16; i++) begin
      b = 16'h0001 << i;
      {secondary_irq_req, primary_irq_req} = b;
      {secondary_irq_enable_reg, primary_irq_enable_reg} = ~b;
      rchk("irq masked", 6'h07, 8'h21);
      {secondary_irq_enable_reg, primary_irq_enable_reg} = b;
      rchk("irq pending", 6'h07, 8'h31);
    end
    {secondary_irq_req, primary_irq_req} = 16'h0000;
    timer_counting = 1'b1;
    rchk("timer free", 6'h07, 8'h29);
    timer_gate_select = 2'h2;
    rchk("timer gated off", 6'h07, 8'h21);
    timer_enabled = 1'b1;
    timer_counting = 1'b0;
    rchk("timer gated on", 6'h07, 8'h29);
    // Control bits of the second register, and the cipher flag
    host.wr(6'h08, 8'hc8);
    rchk("modem_ctl bits", 6'h08, 8'hc0);
    chk("filter forced", 8'h01, {7'h00, filter_high_speed});
    host.wr(6'h08, 8'h00);
    chk("filter protocol", 8'h00, {7'h00, filter_high_speed});
    protocol_high_speed = 1'b1;
    @(negedge core_clk) card_authenticate_done = 1'b1;
    @(negedge core_clk) card_authenticate_done = 1'b0;
    chk("filter follow", 8'h01, {7'h00, filter_high_speed});
    chk("cipher port", 8'h01, {7'h00, card_cipher_active});
    host.wr(6'h08, 8'h08);
    rchk("cipher on", 6'h08, 8'h08);
    chk("encrypt off", 8'h00, {7'h00, cipher_encrypt_enable});
    standard_card_rw = 1'b1;
    #1 chk("encrypt on", 8'h01, {7'h00, cipher_encrypt_enable});
    host.wr(6'h08, 8'h00);
    rchk("cipher cleared", 6'h08, 8'h00);
    // Overheat clear is refused while hot
    @(negedge core_clk) overheat_detect = 1'b1;
    @(negedge core_clk) overheat_detect = 1'b0;
    host.wr(6'h08, 8'h80);
    chk("overheat hot", 8'h01, {7'h00, overheat_error});
    temp_below_limit = 1'b1;
    repeat (3) @(negedge core_clk);
    host.wr(6'h08, 8'h80);
    chk("overheat cleared", 8'h00, {7'h00, overheat_error});
    // CRC mismatch only with checking on; receiver start clears it
    for (int k = 0; k < 2; k++) begin
      receive_crc_check_enable = 1'(k);
      @(negedge core_clk) rx_crc_fail = 1'b1;
      @(negedge core_clk) rx_crc_fail = 1'b0;
      chk("crc error", 8'(k), {7'h00, crc_mismatch_error});
    end
    @(negedge core_clk) rx_startup = 1'b1;
    @(negedge core_clk) rx_startup = 1'b0;
    chk("crc error cleared", 8'h00, {7'h00, crc_mismatch_error});
    // Full transceive pass through every modem code
    {transmit_wait_time_reg, receive_wait_time_reg} = {8'h03, 8'h05};
    wait_for_field_flag = 1'b1;
    transceive_active = 1'b1;
    wait_modem(3'h1);
    host.wr(6'h0d, 8'h80);
    wait_modem(3'h2);
    repeat (20) @(negedge core_clk);
    chk("tx wait for field", 8'h02, {5'h00, modem_state_code});
    rf_field_present = 1'b1;
    wait_modem(3'h3);
    rchk("modem read", 6'h08, 8'h83);
    @(negedge core_clk) tx_done = 1'b1;
    @(negedge core_clk) tx_done = 1'b0;
    wait_modem(3'h4);
    wait_modem(3'h5);
    chk("rx wait length", 8'h01, {7'h00, n >= 6});
    @(negedge core_clk) rx_started = 1'b1;
    @(negedge core_clk) rx_started = 1'b0;
    wait_modem(3'h6);
    @(negedge core_clk) rx_done = 1'b1;
    @(negedge core_clk) rx_done = 1'b0;
    wait_modem(3'h1);
    transceive_active = 1'b0;
    wait_modem(3'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
